// File: include/dacc_pkg.sv
// constants shared by the converter control block
package dacc_pkg;
    // register byte offsets
    localparam logic [4:0] OFS_CONTROL = 5'h00;
    localparam logic [4:0] OFS_SOFT_TRIG = 5'h04;
    localparam logic [4:0] OFS_OUTPUT = 5'h08;
    localparam logic [4:0] OFS_HOLD8R = 5'h0C;
    localparam logic [4:0] OFS_HOLD12L = 5'h10;
    localparam logic [4:0] OFS_HOLD12R = 5'h14;
    // control field positions
    localparam int POS_POWER = 0;
    localparam int POS_DMA = 1;
    localparam int POS_BUFFER = 2;
    localparam int POS_TRIG_ON = 3;
    localparam int POS_MASK_LO = 4;
    localparam int POS_DRIVE = 8;
    localparam int POS_WAVE_LO = 10;
    localparam int POS_TRIGGER_SOURCE_SELECT_LO = 12;
    localparam logic [31:0] CONTROL_WMASK = 32'h0000_7DFF;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    // trigger source and wave codes
    localparam logic [2:0] TRIGGER_SOURCE_SELECT_EXT_LINE = 3'h5;
    localparam logic [2:0] TRIGGER_SOURCE_SELECT_SOFTWARE = 3'h6;
    localparam logic [1:0] WAVE_NOISE = 2'h1;
    localparam logic [3:0] MASK_FULL = 4'hB;
    localparam logic [11:0] LFSR_INIT = 12'hAAA;
    // latency counts in core cycles
    localparam int HW_XFER_CYC = 3;
    localparam int WAVE_STEP_CYC = 3;
    localparam int SW_XFER_CYC = 1;
endpackage

// File: src/dacc_top.sv
// converter control: register slave, triggers, transfer, noise and triangle
`timescale 1ns/1ps
`default_nettype none
module dacc_top
    import dacc_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // avalon-mm slave
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // trigger sources
    input wire logic [4:0] timer_trigger_output_in,
    input wire logic external_event_line_in,
    // dma handshake
    output logic dma_req_out,
    input wire logic dma_ack_in,
    // analog side controls
    output logic channel_power_on_out,
    output logic output_buffer_on_out,
    output logic buffer_drive_select_out,
    output logic [11:0] output_sample_out
);
    logic [31:0] converter_control;
    logic software_trigger_bit;
    logic [11:0] held_sample;
    logic [11:0] output_sample;
    logic [11:0] lfsr;
    logic [11:0] tri_cnt;
    logic tri_down;
    logic [2:0] ext_sync;
    logic [HW_XFER_CYC-2:0] hw_pipe;
    logic [WAVE_STEP_CYC-2:0] step_pipe;
    logic auto_pend;
    logic sw_done;
    logic dma_req;
    logic [31:0] rd_value;
    logic [31:0] wmask;
    logic [31:0] wdata_eff;
    logic acc;
    logic wr_acc;
    logic hw_evt;
    logic hw_fire;
    logic sw_fire;
    logic [11:0] amp_mask;
    logic [11:0] wave_term;
    logic [11:0] next_out;
    logic trigger_on;
    logic dma_request_on;
    logic [3:0] mask_amplitude_select;
    logic [1:0] wave_select;
    logic [2:0] trigger_source_select;

    // control fields
    assign trigger_on = converter_control[POS_TRIG_ON];
    assign dma_request_on = converter_control[POS_DMA];
    assign mask_amplitude_select = converter_control[POS_MASK_LO +: 4];
    assign wave_select = converter_control[POS_WAVE_LO +: 2];
    assign trigger_source_select = converter_control[POS_TRIGGER_SOURCE_SELECT_LO +: 3];

    // analog controls come straight from the control flops, the sample from the output register
    assign channel_power_on_out = converter_control[POS_POWER];
    assign output_buffer_on_out = converter_control[POS_BUFFER];
    assign buffer_drive_select_out = converter_control[POS_DRIVE];
    assign output_sample_out = output_sample;
    assign dma_req_out = dma_req;

    // bus accept: waitrequest drops for exactly one cycle per request
    assign acc = (avs_read_in || avs_write_in) && !avs_waitrequest_out;
    assign wr_acc = avs_write_in && !avs_waitrequest_out;

    // byte lane mask
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign wmask[8*gi +: 8] = {8{avs_byteenable_in[gi]}};
        end
    endgenerate
    assign wdata_eff = (avs_writedata_in & wmask) | (rd_value & ~wmask);

    // readback mux; unmapped offsets read zero
    always_comb begin
        case (avs_address_in)
            OFS_CONTROL: rd_value = converter_control;
            OFS_SOFT_TRIG: rd_value = {31'h0, software_trigger_bit};
            OFS_OUTPUT: rd_value = {20'h0, output_sample};
            OFS_HOLD8R: rd_value = {24'h0, held_sample[11:4]};
            OFS_HOLD12L: rd_value = {16'h0, held_sample, 4'h0};
            OFS_HOLD12R: rd_value = {20'h0, held_sample};
            default: rd_value = 32'h0;
        endcase
    end

    // waitrequest and read data
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h0;
        end else if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out <= avs_read_in ? rd_value : 32'h0;
        end else begin
            avs_waitrequest_out <= 1'b1;
        end
    end

    // control register
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            converter_control <= CONTROL_RESET;
        end else if (wr_acc && avs_address_in == OFS_CONTROL) begin
            converter_control <= wdata_eff & CONTROL_WMASK;
        end
    end

    // hold value in three write formats
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            held_sample <= 12'h0;
        end else if (wr_acc) begin
            case (avs_address_in)
                OFS_HOLD12R: held_sample <= wdata_eff[11:0];
                OFS_HOLD12L: held_sample <= wdata_eff[15:4];
                OFS_HOLD8R: held_sample[11:4] <= wdata_eff[7:0];
                default: held_sample <= held_sample;
            endcase
        end
    end

    // untriggered copy request, one cycle after the hold write
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            auto_pend <= 1'b0;
        end else begin
            auto_pend <= wr_acc && !trigger_on && (avs_address_in == OFS_HOLD12R ||
                avs_address_in == OFS_HOLD12L || avs_address_in == OFS_HOLD8R);
        end
    end

    // external line: two-flop sync, third flop for edge
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            ext_sync <= 3'h0;
        end else begin
            ext_sync <= {ext_sync[1:0], external_event_line_in};
        end
    end

    // trigger source decode
    always_comb begin
        case (trigger_source_select)
            3'h0, 3'h1, 3'h2, 3'h3, 3'h4:
                hw_evt = timer_trigger_output_in[trigger_source_select];
            TRIGGER_SOURCE_SELECT_EXT_LINE: hw_evt = ext_sync[1] && !ext_sync[2];
            default: hw_evt = 1'b0;
        endcase
    end
    assign hw_fire = trigger_on && hw_evt;
    assign sw_fire = trigger_on && software_trigger_bit && !sw_done &&
        trigger_source_select == TRIGGER_SOURCE_SELECT_SOFTWARE;

    // latency pipes; the last stage drives the update edge, so the result shows 3 cycles on
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            hw_pipe <= '0;
            step_pipe <= '0;
        end else begin
            hw_pipe <= {hw_pipe[HW_XFER_CYC-3:0], hw_fire};
            step_pipe <= {step_pipe[WAVE_STEP_CYC-3:0], hw_fire || sw_fire};
        end
    end

    // software trigger bit; a bus set wins over the hardware clear
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            software_trigger_bit <= 1'b0;
            sw_done <= 1'b0;
        end else begin
            sw_done <= sw_fire;
            if (wr_acc && avs_address_in == OFS_SOFT_TRIG) begin
                software_trigger_bit <= wdata_eff[0];
            end else if (sw_done) begin
                software_trigger_bit <= 1'b0;
            end
        end
    end

    // dma request: held until acknowledged, extra triggers merge
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            dma_req <= 1'b0;
        end else if (hw_fire && dma_request_on) begin
            dma_req <= 1'b1;
        end else if (dma_ack_in) begin
            dma_req <= 1'b0;
        end
    end

    // mask and amplitude from the select field
    always_comb begin
        if (mask_amplitude_select >= MASK_FULL) begin
            amp_mask = 12'hFFF;
        end else begin
            amp_mask = 12'((13'h2 << mask_amplitude_select) - 13'h1);
        end
    end

    // wave term added to the hold value, overflow dropped
    always_comb begin
        if (!trigger_on || wave_select == 2'h0) begin
            wave_term = 12'h0;
        end else if (wave_select == WAVE_NOISE) begin
            wave_term = lfsr & amp_mask;
        end else begin
            wave_term = tri_cnt;
        end
    end
    assign next_out = held_sample + wave_term;

    // output register: hardware, software, then untriggered copy
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            output_sample <= 12'h0;
        end else if (hw_pipe[HW_XFER_CYC-2] || sw_fire) begin
            output_sample <= next_out;
        end else if (auto_pend) begin
            output_sample <= held_sample;
        end
    end

    // noise shift register
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            lfsr <= LFSR_INIT;
        end else if (step_pipe[WAVE_STEP_CYC-2] && trigger_on && wave_select == WAVE_NOISE) begin
            lfsr <= {lfsr[10:0], lfsr[11] ^ lfsr[5] ^ lfsr[3] ^ lfsr[0]};
        end
    end

    // triangle counter
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            tri_cnt <= 12'h0;
            tri_down <= 1'b0;
        end else if (step_pipe[WAVE_STEP_CYC-2] && trigger_on && wave_select[1]) begin
            if (!tri_down) begin
                if (tri_cnt < amp_mask) begin
                    tri_cnt <= tri_cnt + 12'h1;
                end else begin
                    tri_down <= 1'b1;
                    tri_cnt <= tri_cnt - 12'h1;
                end
            end else if (tri_cnt != 12'h0) begin
                tri_cnt <= tri_cnt - 12'h1;
            end else begin
                tri_down <= 1'b0;
                tri_cnt <= 12'h1;
            end
        end
    end

    // checks
    a_hold_right: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        wr_acc && avs_address_in == OFS_HOLD12R && avs_byteenable_in == 4'hF
        |=> held_sample == $past(avs_writedata_in[11:0]))
        else $error("right aligned hold write wrong");

    a_hold_left: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        wr_acc && avs_address_in == OFS_HOLD12L && avs_byteenable_in == 4'hF
        |=> held_sample == $past(avs_writedata_in[15:4]))
        else $error("left aligned hold write wrong");

    a_hold_byte: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        wr_acc && avs_address_in == OFS_HOLD8R && avs_byteenable_in == 4'hF
        |=> held_sample == {$past(avs_writedata_in[7:0]), $past(held_sample[3:0])})
        else $error("byte hold write wrong");

    a_hw_latency: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        hw_fire |-> ##2 hw_pipe[HW_XFER_CYC-2] ##1 output_sample == $past(next_out))
        else $error("hardware transfer not after three cycles");

    a_sw_latency: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        sw_fire |=> output_sample == $past(next_out) && !sw_fire)
        else $error("software transfer not after one cycle");

    a_auto_copy: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        wr_acc && !trigger_on && avs_address_in == OFS_HOLD12R && avs_byteenable_in == 4'hF
        ##1 !hw_pipe[HW_XFER_CYC-2] |=> output_sample == $past(held_sample))
        else $error("untriggered copy missing");

    a_sw_clear: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        sw_fire ##1 !(wr_acc && avs_address_in == OFS_SOFT_TRIG) |=> !software_trigger_bit)
        else $error("software trigger bit not cleared");

    a_dma_raise: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        hw_fire && dma_request_on |=> dma_req_out)
        else $error("dma request not raised");

    a_dma_no_queue: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        dma_req_out && dma_ack_in && !(hw_fire && dma_request_on) |=> !dma_req_out)
        else $error("dma request queued");

    a_lfsr_init: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        !$past(nrst_in) |-> lfsr == LFSR_INIT)
        else $error("shift register reset value wrong");

    a_wave_gate: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        !trigger_on |=> $stable(lfsr) && $stable(tri_cnt))
        else $error("wave advanced without triggering");

    a_tri_up: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        step_pipe[WAVE_STEP_CYC-2] && trigger_on && wave_select[1] && !tri_down &&
        tri_cnt < amp_mask |=> tri_cnt == $past(tri_cnt) + 12'h1)
        else $error("triangle did not count up");

    a_tri_down: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        step_pipe[WAVE_STEP_CYC-2] && trigger_on && wave_select[1] && tri_down &&
        tri_cnt != 12'h0 |=> tri_cnt == $past(tri_cnt) - 12'h1)
        else $error("triangle did not count down");

    a_lfsr_step: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        step_pipe[WAVE_STEP_CYC-2] && trigger_on && wave_select == WAVE_NOISE
        |=> lfsr == {$past(lfsr[10:0]), $past(lfsr[11] ^ lfsr[5] ^ lfsr[3] ^ lfsr[0])})
        else $error("shift register step wrong");

    a_dma_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        dma_req_out && !dma_ack_in |=> dma_req_out)
        else $error("dma request dropped before service");

    a_quiet_output: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        !trigger_on && !auto_pend && !hw_pipe[HW_XFER_CYC-2] |=> $stable(output_sample))
        else $error("output moved with no transfer");

    a_null_source: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        trigger_source_select == 3'h7 |-> !hw_fire && !sw_fire)
        else $error("code seven produced a trigger");

endmodule
`default_nettype wire

// File: testbench/dacc_dma_model.sv
// dma controller stand-in that answers converter requests
`timescale 1ns/1ps
`default_nettype none
module dacc_dma_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // request handshake
    input wire logic req_in,
    input wire logic [3:0] lat_in,
    output logic ack_out,
    output var int n_ack_out
);
    logic [3:0] cnt;

    // one ack pulse per request after lat_in waiting cycles
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ack_out <= 1'b0;
            cnt <= 4'h0;
            n_ack_out <= 0;
        end else begin
            ack_out <= 1'b0;
            if (ack_out) begin
                cnt <= 4'h0; // request drops the cycle after the ack
            end else if (req_in) begin
                if (cnt >= lat_in) begin
                    ack_out <= 1'b1;
                    n_ack_out <= n_ack_out + 1;
                    cnt <= 4'h0;
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import dacc_pkg::*;
;
    logic clk, nrst, rdq, wrq, wq, ext, dreq, dack, pwr, bufo, drv;
    logic [4:0] adr, trig;
    logic [31:0] wd, rdat, q;
    logic [11:0] smp, l, p, e;
    logic [3:0] lat;
    int nack, t, up, base;
    int mismatches = 0;
    int n_compared = 0;

    dacc_top dut_u (.core_clk_in(clk), .nrst_in(nrst), .avs_address_in(adr),
        .avs_read_in(rdq), .avs_write_in(wrq), .avs_writedata_in(wd),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(wq),
        .timer_trigger_output_in(trig), .external_event_line_in(ext),
        .dma_req_out(dreq), .dma_ack_in(dack), .channel_power_on_out(pwr),
        .output_buffer_on_out(bufo), .buffer_drive_select_out(drv),
        .output_sample_out(smp));
    dacc_dma_model dma_u (.clk_in(clk), .nrst_in(nrst), .req_in(dreq), .lat_in(lat),
        .ack_out(dack), .n_ack_out(nack));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(string nm, logic [31:0] ex, logic [31:0] sn);
        n_compared++;
        if (sn !== ex) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, ex, sn);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
        int n;
        @(posedge clk);
        wrq <= w;
        rdq <= !w;
        adr <= a;
        wd <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wq !== 1'b0 && n < 40);
        if (n >= 40) chk("waitrequest", 32'h0, 32'h1);
        q = rdat;
        wrq <= 1'b0;
        rdq <= 1'b0;
    endtask

    task automatic rc(logic [4:0] a, logic [31:0] ex);
        bus(1'b0, a, 32'h0);
        chk("readback", ex, q);
    endtask

    // hold or software trigger write, output checked shortly after
    task automatic hw(logic [4:0] a, logic [31:0] d, logic [11:0] ex);
        bus(1'b1, a, d);
        tick(2);
        #1 chk("output", 32'(ex), 32'(smp));
    endtask

    // channel held off while source and mask change
    task automatic cfg(logic [31:0] v);
        bus(1'b1, OFS_CONTROL, 32'h0);
        bus(1'b1, OFS_CONTROL, v);
    endtask

    // timer pulse; output old two cycles later, new in the third
    task automatic fire(logic [4:0] tb, logic [11:0] o, logic [11:0] nw);
        @(posedge clk);
        trig <= tb;
        @(posedge clk);
        trig <= 5'h00;
        @(posedge clk);
        #1 chk("held", 32'(o), 32'(smp));
        @(posedge clk);
        #1 chk("moved", 32'(nw), 32'(smp));
    endtask

    task automatic rst();
        @(posedge clk);
        nrst <= 1'b0;
        tick(2);
        nrst <= 1'b1;
    endtask

    task automatic endt(string s);
        $display("test %s done", s);
    endtask

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    function automatic logic [31:0] ctl(logic [2:0] ts, logic [1:0] wv, logic [3:0] m, logic dm);
        ctl = (32'(ts) << POS_TRIGGER_SOURCE_SELECT_LO) | (32'(wv) << POS_WAVE_LO) | (32'(m) << POS_MASK_LO);
        ctl = ctl | (32'(dm) << POS_DMA) | (32'h1 << POS_TRIG_ON);
    endfunction

    function automatic logic [11:0] msk(logic [3:0] m);
        msk = (m >= MASK_FULL) ? 12'hFFF : 12'((13'h0001 << (m + 4'h1)) - 13'h0001);
    endfunction

    // hang guard
    initial begin
        tick(30000);
        mismatches++;
        give_verdict();
    end

    // test sequence
    initial begin
        {nrst, rdq, wrq, ext} = 4'h0;
        adr = 5'h00;
        wd = 32'h0;
        trig = 5'h00;
        lat = 4'h0;
        rst();
        rc(OFS_CONTROL, CONTROL_RESET);
        hw(OFS_HOLD12R, 32'hFFFF_F123, 12'h123);
        hw(OFS_HOLD12L, 32'h0000_ABCD, 12'hABC);
        hw(OFS_HOLD8R, 32'h0000_015A, 12'h5AC);
        bus(1'b1, OFS_OUTPUT, 32'h0000_0777);
        rc(OFS_OUTPUT, 32'h0000_05AC);
        rc(OFS_HOLD12L, 32'h0000_5AC0);
        rc(OFS_HOLD8R, 32'h0000_005A);
        rc(5'h18, 32'h0);
        endt("formats");
        cfg(ctl(TRIGGER_SOURCE_SELECT_SOFTWARE, 2'h0, 4'h0, 1'b0));
        hw(OFS_HOLD12R, 32'h0000_0246, 12'h5AC);
        hw(OFS_SOFT_TRIG, 32'h0000_0001, 12'h246);
        rc(OFS_SOFT_TRIG, 32'h0);
        endt("software");
        bus(1'b1, OFS_CONTROL, 32'hFFFF_FFFE);
        rc(OFS_CONTROL, CONTROL_WMASK & 32'hFFFF_FFFE);
        chk("power", 32'h0, 32'(pwr));
        chk("buffer", 32'h1, 32'(bufo));
        chk("drive", 32'h1, 32'(drv));
        bus(1'b1, OFS_CONTROL, 32'hFFFF_FFFF);
        #1 chk("power", 32'h1, 32'(pwr));
        fire(5'h1F, 12'h246, 12'h246);
        chk("dma idle", 32'h0, 32'(dreq));
        endt("control");
        p = 12'h246;
        for (int k = 0; k < 5; k++) begin
            cfg(ctl(3'(k), 2'h0, 4'h0, 1'b0));
            bus(1'b1, OFS_HOLD12R, 32'h0000_0300 + k);
            fire(5'h01 << ((k + 1) % 5), p, p);
            fire(5'h01 << k, p, 12'(12'h300 + k));
            p = 12'(12'h300 + k);
        end
        cfg(ctl(TRIGGER_SOURCE_SELECT_EXT_LINE, 2'h0, 4'h0, 1'b0));
        bus(1'b1, OFS_HOLD12R, 32'h0000_03C3);
        @(posedge clk);
        ext <= 1'b1;
        tick(3);
        #1 chk("held", 32'(p), 32'(smp));
        tick(6);
        ext <= 1'b0;
        #1 chk("moved", 32'h3C3, 32'(smp));
        p = 12'h3C3;
        endt("hardware");
        for (int i = 0; i < 2; i++) begin
            lat <= (i == 1) ? 4'h9 : 4'h0;
            cfg(ctl(3'h0, 2'h0, 4'h0, 1'b1));
            bus(1'b1, OFS_HOLD12R, 32'h0000_0410 + i);
            base = nack;
            fire(5'h01, p, 12'(12'h410 + i));
            fire(5'h01, 12'(12'h410 + i), 12'(12'h410 + i));
            tick(20);
            chk("dma acks", (i == 1) ? 32'h1 : 32'h2, 32'(nack - base));
            p = 12'(12'h410 + i);
        end
        endt("dma");
        for (int m = 3; m < 12; m += 8) begin
            rst();
            cfg(ctl(3'h0, WAVE_NOISE, 4'(m), 1'b0));
            bus(1'b1, OFS_HOLD12R, 32'h0000_0F00);
            l = LFSR_INIT;
            p = 12'h000;
            repeat (3) begin
                e = 12'hF00 + (l & msk(4'(m)));
                fire(5'h01, p, e);
                p = e;
                l = {l[10:0], l[11] ^ l[5] ^ l[3] ^ l[0]};
            end
        end
        endt("noise");
        for (int w = 2; w < 4; w++) begin
            rst();
            cfg(ctl(3'h0, 2'(w), 4'h1, 1'b0));
            bus(1'b1, OFS_HOLD12R, 32'h0000_0FFE);
            {t, up} = {32'sd0, 32'sd1};
            p = 12'h000;
            repeat (8) begin
                e = 12'hFFE + 12'(t);
                fire(5'h01, p, e);
                p = e;
                if (up == 1 && t == 3) up = 0;
                else if (up == 0 && t == 0) up = 1;
                t = (up == 1) ? t + 1 : t - 1;
            end
        end
        endt("triangle");
        give_verdict();
    end
endmodule
`default_nettype wire
